// ==== dsw_pkg.sv ====
// data-space window and bank decode: shared constants
// assumes an 8-bit data space and a 12-bit program memory address
package dsw_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned OFS_W     = 6;   // offset inside one 64-byte window or bank
  localparam int unsigned WIN_W     = 6;   // window position field, bits 5..0
  localparam int unsigned PM_ADDR_W = WIN_W + OFS_W;

  // ----------------------------------------------------------------
  // data-space address map
  // ----------------------------------------------------------------
  localparam logic [7:0] BANK_LO    = 8'h00;
  localparam logic [7:0] BANK_HI    = 8'h3F;
  localparam logic [7:0] WIN_LO     = 8'h40;
  localparam logic [7:0] WIN_HI     = 8'h7F;
  localparam logic [7:0] RAM_LO     = 8'h84;  // 60 bytes of base ram
  localparam logic [7:0] RAM_HI     = 8'hBF;
  localparam logic [7:0] PDATA_A    = 8'hC0;
  localparam logic [7:0] PDATA_B    = 8'hC1;
  localparam logic [7:0] PDATA_C    = 8'hC3;
  localparam logic [7:0] PDIR_A     = 8'hC4;
  localparam logic [7:0] PDIR_B     = 8'hC5;
  localparam logic [7:0] PDIR_C     = 8'hC6;
  localparam logic [7:0] RSVD_C7    = 8'hC7;
  localparam logic [7:0] INT_OPTION = 8'hC8;
  localparam logic [7:0] ROM_WINDOW_POSITION = 8'hC9;
  localparam logic [7:0] PAGE_BANK_SELECT    = 8'hCB;
  localparam logic [7:0] TIMER_LO   = 8'hD2;  // prescaler, counter, status per timer
  localparam logic [7:0] TIMER_HI   = 8'hD7;
  localparam logic [7:0] WATCHDOG   = 8'hD8;

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  localparam logic [7:0] WIN_MASK      = 8'h3F;  // bits 7,6 unused
  localparam logic [7:0] BANK_MASK     = 8'h1B;  // bits 7..5 and 2 unused
  localparam int unsigned SEL_EEPROM_PAGE0 = 0;
  localparam int unsigned SEL_EEPROM_PAGE1 = 1;
  localparam int unsigned SEL_RAM_PAGE1    = 3;
  localparam int unsigned SEL_RAM_PAGE2    = 4;
  localparam logic [7:0] BANK_NONE     = 8'h00;
  localparam logic [7:0] BANK_EE0      = 8'h01;
  localparam logic [7:0] BANK_EE1      = 8'h02;
  localparam logic [7:0] BANK_RAM1_NA  = 8'h08;
  localparam logic [7:0] BANK_RAM2     = 8'h10;

endpackage : dsw_pkg

// ==== dsw_range.sv ====
// address range compare for the data-space decoder
// assumes lo <= hi and both fit the address width
`timescale 1ns/100ps
`default_nettype none
module dsw_range #(
  parameter int unsigned    AW = 8,
  parameter logic [AW-1:0]  LO = '0,
  parameter logic [AW-1:0]  HI = '0
) (
  input  wire logic [AW-1:0] addr_i,
  output logic               hit_o
);

  initial begin
    if (LO > HI) $error("dsw_range: LO above HI");
  end

  // inclusive bounds on both ends
  assign hit_o = (addr_i >= LO) && (addr_i <= HI);

endmodule : dsw_range
`default_nettype wire

// ==== dsw_wo_reg.sv ====
// write-only register that is not cleared by reset
// assumes the write strobe is a one-cycle pulse from the decoder
`timescale 1ns/100ps
`default_nettype none
module dsw_wo_reg #(
  parameter int unsigned  W    = 8,
  parameter logic [W-1:0] MASK = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] value_o,
  output logic              written_o
);

  logic [W-1:0] value;
  logic [W-1:0] next_value;
  logic         written;
  logic         next_written;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    next_value   = wr_i ? (data_i & MASK) : value;  // unused bits store zero
    next_written = written | wr_i;
  end

  // contents survive reset on purpose; only the written flag clears
  always_ff @(posedge clk_i) begin
    value <= next_value;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      written <= 1'b0;
    end else begin
      written <= next_written;
    end
  end

  assign value_o   = value;
  assign written_o = written;

endmodule : dsw_wo_reg
`default_nettype wire

// ==== dsw_decode.sv ====
// data-space decoder: read-only window onto program memory, banked page
// select for the low 64 bytes, and base ram / peripheral address decode
// assumes the core presents one access per cycle with RD_I or WR_I high
//
// Functional notes
// - Reads at 40h..7Fh go to program memory as a read-only window.
// - Window address is position register above the low six address bits.
// - Position bits 5..0 move the window in 64-byte steps; bits 7,6 unused.
// - Position register survives reset; software writes it before window reads.
// - Bank select at CBh is write-only; bits 4,3,1,0 pick pages.
// - Accesses at 00h..3Fh reach the selected bank at the same offset.
// - Codes: 00h none, 01h/02h eeprom pages, 10h ram2, 08h unavailable.
// - Bank select survives initialization; software writes it before bank use.
// - Bank select keeps its value across interrupts and calls.
// - Base ram of 60 bytes plus one ram and two eeprom banks.
// - Port data at C0h,C1h,C3h, direction at C4h..C6h, C7h reserved.
// - Timer registers at D2h..D7h, watchdog register at D8h.
// - C8h, C9h and CBh are write-only locations.
// - Eeprom bytes read and write directly at banked addresses.
`timescale 1ns/100ps
`default_nettype none
module dsw_decode #(
  parameter int unsigned ADDR_W = dsw_pkg::ADDR_W,
  parameter int unsigned DATA_W = dsw_pkg::DATA_W
) (
  input  wire logic                        CLK_I,
  input  wire logic                        RSTN_I,
  input  wire logic                        RD_I,
  input  wire logic                        WR_I,
  input  wire logic [ADDR_W-1:0]           ADDR_I,
  input  wire logic [DATA_W-1:0]           WDATA_I,
  output logic                             PM_RD_O,
  output logic      [dsw_pkg::PM_ADDR_W-1:0] PM_ADDR_O,
  output logic      [2:0]                  BANK_SEL_O,
  output logic                             BANK_RD_O,
  output logic                             BANK_WR_O,
  output logic      [dsw_pkg::OFS_W-1:0]   OFS_O,
  output logic      [DATA_W-1:0]           WDATA_O,
  output logic                             BASE_RAM_O,
  output logic      [2:0]                  PORT_DATA_O,
  output logic      [2:0]                  PORT_DIR_O,
  output logic      [5:0]                  TIMER_O,
  output logic                             WATCHDOG_O,
  output logic                             INT_OPTION_WR_O,
  output logic                             WO_READ_O,
  output logic                             BANK_MULTI_O,
  output logic                             WIN_VALID_O,
  output logic                             BANK_VALID_O
);

  initial begin
    if (ADDR_W != 8 || DATA_W != 8) $error("dsw_decode: only an 8-bit data space is served");
  end

  // ----------------------------------------------------------------
  // address ranges
  // ----------------------------------------------------------------
  logic in_bank;
  logic in_win;
  logic in_ram;
  logic in_timer;

  dsw_range #(.AW(8), .LO(dsw_pkg::BANK_LO), .HI(dsw_pkg::BANK_HI)) u_bank_rng (
    .addr_i (ADDR_I),
    .hit_o  (in_bank)
  );
  dsw_range #(.AW(8), .LO(dsw_pkg::WIN_LO), .HI(dsw_pkg::WIN_HI)) u_win_rng (
    .addr_i (ADDR_I),
    .hit_o  (in_win)
  );
  dsw_range #(.AW(8), .LO(dsw_pkg::RAM_LO), .HI(dsw_pkg::RAM_HI)) u_ram_rng (
    .addr_i (ADDR_I),
    .hit_o  (in_ram)
  );
  dsw_range #(.AW(8), .LO(dsw_pkg::TIMER_LO), .HI(dsw_pkg::TIMER_HI)) u_tim_rng (
    .addr_i (ADDR_I),
    .hit_o  (in_timer)
  );

  // ----------------------------------------------------------------
  // write-only registers
  // ----------------------------------------------------------------
  logic       acc;
  logic       win_wr;
  logic       bank_wr;
  logic [7:0] rom_window_position;
  logic [7:0] page_bank_select;

  assign acc     = RD_I | WR_I;
  assign win_wr  = WR_I && (ADDR_I == dsw_pkg::ROM_WINDOW_POSITION);
  assign bank_wr = WR_I && (ADDR_I == dsw_pkg::PAGE_BANK_SELECT);

  // no reset on contents: both hold whatever was last written
  dsw_wo_reg #(.W(8), .MASK(dsw_pkg::WIN_MASK)) u_win_reg (
    .clk_i     (CLK_I),
    .rstn_i    (RSTN_I),
    .wr_i      (win_wr),
    .data_i    (WDATA_I),
    .value_o   (rom_window_position),
    .written_o (WIN_VALID_O)
  );
  dsw_wo_reg #(.W(8), .MASK(dsw_pkg::BANK_MASK)) u_bank_reg (
    .clk_i     (CLK_I),
    .rstn_i    (RSTN_I),
    .wr_i      (bank_wr),
    .data_i    (WDATA_I),
    .value_o   (page_bank_select),
    .written_o (BANK_VALID_O)
  );

  logic [5:0] window_upper_bits;
  logic       sel_eeprom_page0;
  logic       sel_eeprom_page1;
  logic       sel_ram_page1;
  logic       sel_ram_page2;

  // field split; ram page 1 decodes but has no page behind it
  assign window_upper_bits = rom_window_position[dsw_pkg::WIN_W-1:0];
  assign sel_eeprom_page0  = page_bank_select[dsw_pkg::SEL_EEPROM_PAGE0];
  assign sel_eeprom_page1  = page_bank_select[dsw_pkg::SEL_EEPROM_PAGE1];
  assign sel_ram_page1     = page_bank_select[dsw_pkg::SEL_RAM_PAGE1];
  assign sel_ram_page2     = page_bank_select[dsw_pkg::SEL_RAM_PAGE2];

  // ----------------------------------------------------------------
  // decode stage
  // ----------------------------------------------------------------
  logic [11:0] pm_addr;
  logic [11:0] next_pm_addr;
  logic        pm_rd;
  logic        next_pm_rd;
  logic [2:0]  bank_sel;
  logic [2:0]  next_bank_sel;
  logic        bank_rd;
  logic        next_bank_rd;
  logic        bank_wr_q;
  logic        next_bank_wr;
  logic [5:0]  ofs;
  logic [5:0]  next_ofs;
  logic [7:0]  wdata;
  logic [7:0]  next_wdata;
  logic        base_ram;
  logic        next_base_ram;
  logic [2:0]  port_data;
  logic [2:0]  next_port_data;
  logic [2:0]  port_dir;
  logic [2:0]  next_port_dir;
  logic [5:0]  timer;
  logic [5:0]  next_timer;
  logic        wdog;
  logic        next_wdog;
  logic        intopt_wr;
  logic        next_intopt_wr;
  logic        wo_read;
  logic        next_wo_read;
  logic        multi;
  logic        next_multi;
  logic        wo_addr;
  logic [7:0]  tim_idx;

  // every strobe is one cycle wide and follows its access by one edge;
  // a register written at edge n is already used for the access at n+1
  always_comb begin
    tim_idx        = ADDR_I - dsw_pkg::TIMER_LO;
    wo_addr        = (ADDR_I == dsw_pkg::INT_OPTION) || (ADDR_I == dsw_pkg::ROM_WINDOW_POSITION) ||
                     (ADDR_I == dsw_pkg::PAGE_BANK_SELECT);
    next_pm_rd     = RD_I && in_win;
    next_pm_addr   = {window_upper_bits, ADDR_I[dsw_pkg::OFS_W-1:0]};
    next_ofs       = ADDR_I[dsw_pkg::OFS_W-1:0];
    next_wdata     = WDATA_I;
    next_bank_rd   = RD_I && in_bank;
    next_bank_wr   = WR_I && in_bank;
    // several set bits drive several pages at once, as the hardware would
    next_bank_sel  = (acc && in_bank) ? {sel_ram_page2, sel_eeprom_page1, sel_eeprom_page0} : 3'h0;
    next_multi     = acc && in_bank &&
                     ($countones({sel_ram_page2, sel_ram_page1, sel_eeprom_page1, sel_eeprom_page0}) > 1);
    next_base_ram  = acc && in_ram;
    next_port_data = 3'h0;
    next_port_dir  = 3'h0;
    next_timer     = 6'h0;
    next_wdog      = acc && (ADDR_I == dsw_pkg::WATCHDOG);
    if (acc) begin
      next_port_data[0] = (ADDR_I == dsw_pkg::PDATA_A);
      next_port_data[1] = (ADDR_I == dsw_pkg::PDATA_B);
      next_port_data[2] = (ADDR_I == dsw_pkg::PDATA_C);
      next_port_dir[0]  = (ADDR_I == dsw_pkg::PDIR_A);
      next_port_dir[1]  = (ADDR_I == dsw_pkg::PDIR_B);
      next_port_dir[2]  = (ADDR_I == dsw_pkg::PDIR_C);
      if (in_timer) begin
        next_timer[tim_idx[2:0]] = 1'b1;
      end
    end
    next_intopt_wr = WR_I && (ADDR_I == dsw_pkg::INT_OPTION);
    // reads of write-only cells return nothing useful; flag them instead
    next_wo_read   = RD_I && wo_addr;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pm_rd     <= 1'b0;
      pm_addr   <= 12'h000;
      bank_sel  <= 3'h0;
      bank_rd   <= 1'b0;
      bank_wr_q <= 1'b0;
      ofs       <= 6'h00;
      wdata     <= 8'h00;
      base_ram  <= 1'b0;
      port_data <= 3'h0;
      port_dir  <= 3'h0;
      timer     <= 6'h00;
      wdog      <= 1'b0;
      intopt_wr <= 1'b0;
      wo_read   <= 1'b0;
      multi     <= 1'b0;
    end else begin
      pm_rd     <= next_pm_rd;
      pm_addr   <= next_pm_addr;
      bank_sel  <= next_bank_sel;
      bank_rd   <= next_bank_rd;
      bank_wr_q <= next_bank_wr;
      ofs       <= next_ofs;
      wdata     <= next_wdata;
      base_ram  <= next_base_ram;
      port_data <= next_port_data;
      port_dir  <= next_port_dir;
      timer     <= next_timer;
      wdog      <= next_wdog;
      intopt_wr <= next_intopt_wr;
      wo_read   <= next_wo_read;
      multi     <= next_multi;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PM_RD_O         = pm_rd;
  assign PM_ADDR_O       = pm_addr;
  assign BANK_SEL_O      = bank_sel;
  assign BANK_RD_O       = bank_rd;
  assign BANK_WR_O       = bank_wr_q;
  assign OFS_O           = ofs;
  assign WDATA_O         = wdata;
  assign BASE_RAM_O      = base_ram;
  assign PORT_DATA_O     = port_data;
  assign PORT_DIR_O      = port_dir;
  assign TIMER_O         = timer;
  assign WATCHDOG_O      = wdog;
  assign INT_OPTION_WR_O = intopt_wr;
  assign WO_READ_O       = wo_read;
  assign BANK_MULTI_O    = multi;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_win_read_addr: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (RD_I && ADDR_I[7:6] == 2'b01) |=>
      (PM_RD_O && PM_ADDR_O == {$past(rom_window_position[5:0]), $past(ADDR_I[5:0])}))
    else $error("window read address wrong");

  a_win_no_write: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (WR_I && !RD_I && ADDR_I[7:6] == 2'b01) |=> !PM_RD_O)
    else $error("write reached program memory");

  a_win_step_64: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (WR_I && ADDR_I == 8'hC9) ##1 (RD_I && ADDR_I == 8'h40) |=>
      (PM_ADDR_O == {$past(WDATA_I[5:0], 2), 6'h00}))
    else $error("window position not applied to next read");

  a_bank_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (BANK_VALID_O && !(WR_I && ADDR_I == 8'hCB)) |=> $stable(page_bank_select))
    else $error("bank select changed without a write");

  a_win_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (WIN_VALID_O && !(WR_I && ADDR_I == 8'hC9)) |=> $stable(rom_window_position))
    else $error("window position changed without a write");

  a_bank_route: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (acc && ADDR_I <= 8'h3F && page_bank_select == 8'h01) |=>
      (BANK_SEL_O == 3'b001 && OFS_O == $past(ADDR_I[5:0]))
      ##1 (BANK_SEL_O == 3'b000 || $past(acc && ADDR_I <= 8'h3F)))
    else $error("eeprom page 0 not routed");

  a_bank_unavail: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (acc && ADDR_I <= 8'h3F && (page_bank_select == 8'h08 || page_bank_select == 8'h00))
      |=> (BANK_SEL_O == 3'b000 && !BANK_MULTI_O))
    else $error("page selected for empty or unavailable code");

  a_port_map: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (acc && ADDR_I == 8'hC7) |=> (PORT_DATA_O == 3'h0 && PORT_DIR_O == 3'h0))
    else $error("reserved address decoded as a port");

  a_timer_map: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (acc && ADDR_I == 8'hD7) |=> (TIMER_O == 6'h20 && !WATCHDOG_O))
    else $error("timer 2 status not decoded");

  a_wo_read_flag: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (RD_I && (ADDR_I == 8'hC8 || ADDR_I == 8'hC9 || ADDR_I == 8'hCB)) |=>
      (WO_READ_O && !PM_RD_O && BANK_SEL_O == 3'h0))
    else $error("read of write-only cell not flagged");

  a_base_ram: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (acc && (ADDR_I == 8'h83 || ADDR_I == 8'hC0)) |=> !BASE_RAM_O)
    else $error("base ram decoded outside its 60 bytes");

endmodule : dsw_decode
`default_nettype wire

// ==== dsw_core_model.sv ====
// core-side model: presents one data-space access per call
// assumes the caller invokes drive just after a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module dsw_core_model (
  output logic       rd_o,
  output logic       wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // ----------------------------------------------------------------
  // request drive
  // ----------------------------------------------------------------
  // idle at time zero so nothing is taken during reset
  initial begin
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end

  // write data is only meaningful with a write; otherwise it keeps toggling
  // so a stale value can never pass for a captured one
  // the position and bank registers are written before use, at most one bank
  // bit set, write-only cells never read, unless the bench commands otherwise
  task automatic drive(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    rd_o    = r;
    wr_o    = w;
    addr_o  = a;
    wdata_o = w ? d : ~wdata_o;
  endtask : drive
endmodule : dsw_core_model
`default_nettype wire

// ==== data_space_window_bank_decode_bench.sv ====
// self-checking bench for the data-space window and bank decoder
// assumes dsw_pkg, dsw_decode and dsw_core_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module data_space_window_bank_decode_bench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        rd, wr, pm_rd, bank_rd, bank_wr, base_ram, watchdog;
  logic        int_opt_wr, wo_read, bank_multi, win_valid, bank_valid;
  logic [7:0]  addr, wdata, wdata_q, win, bank;
  logic [dsw_pkg::PM_ADDR_W-1:0] pm_addr;
  logic [2:0]  bank_sel, port_data, port_dir;
  logic [5:0]  ofs, timer;
  bit          winv, bankv, wknown, bknown;
  int          n_mismatch = 0;
  int          comparisons = 0;
  logic [7:0]  wp[4] = '{8'h00, 8'h3F, 8'hC5, 8'h80};
  logic [7:0]  bc[8] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h10, 8'h03, 8'h1B, 8'hFF};

  // ----------------------------------------------------------------
  // clock, design and core model
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  dsw_core_model u_core (.rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

  dsw_decode u_dut (
    .CLK_I(clk), .RSTN_I(rstn), .RD_I(rd), .WR_I(wr), .ADDR_I(addr), .WDATA_I(wdata),
    .PM_RD_O(pm_rd), .PM_ADDR_O(pm_addr), .BANK_SEL_O(bank_sel), .BANK_RD_O(bank_rd),
    .BANK_WR_O(bank_wr), .OFS_O(ofs), .WDATA_O(wdata_q), .BASE_RAM_O(base_ram),
    .PORT_DATA_O(port_data), .PORT_DIR_O(port_dir), .TIMER_O(timer), .WATCHDOG_O(watchdog),
    .INT_OPTION_WR_O(int_opt_wr), .WO_READ_O(wo_read), .BANK_MULTI_O(bank_multi),
    .WIN_VALID_O(win_valid), .BANK_VALID_O(bank_valid));

  // ----------------------------------------------------------------
  // checking tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // one access: model predicts, the next falling edge sees the registered strobes
  task automatic op(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    logic acc, bk, inw;
    acc = r | w;
    bk  = acc && (a <= dsw_pkg::BANK_HI);
    inw = r && (a >= dsw_pkg::WIN_LO) && (a <= dsw_pkg::WIN_HI);
    // the ram image is updated before the register write goes out
    if (w && a == dsw_pkg::ROM_WINDOW_POSITION) begin
      win = d & dsw_pkg::WIN_MASK;
      winv = 1'b1;
      wknown = 1'b1;
    end
    if (w && a == dsw_pkg::PAGE_BANK_SELECT) begin
      bank = d & dsw_pkg::BANK_MASK;
      bankv = 1'b1;
      bknown = 1'b1;
    end
    u_core.drive(r, w, a, d);
    @(negedge clk);
    chk(pm_rd, inw);
    if (inw && wknown) chk(pm_addr, {win[5:0], a[5:0]});
    chk(bank_rd, r && bk);
    chk(bank_wr, w && bk);
    if (!bk || bknown) chk(bank_sel, bk ? {bank[4], bank[1], bank[0]} : 3'h0);
    if (!bk || bknown) chk(bank_multi, bk && $countones(bank) > 1);
    if (bk || inw) chk(ofs, a[5:0]);
    if (w && bk) chk(wdata_q, d);
    chk(base_ram, acc && a >= dsw_pkg::RAM_LO && a <= dsw_pkg::RAM_HI);
    chk(port_data, acc ? {a == 8'hC3, a == 8'hC1, a == 8'hC0} : 3'h0);
    chk(port_dir, acc ? {a == 8'hC6, a == 8'hC5, a == 8'hC4} : 3'h0);
    chk(timer, (acc && a >= 8'hD2 && a <= 8'hD7) ? 6'(6'h01 << (a - 8'hD2)) : 6'h00);
    chk(watchdog, acc && a == 8'hD8);
    chk(int_opt_wr, w && a == 8'hC8);
    chk(wo_read, r && (a == 8'hC8 || a == 8'hC9 || a == 8'hCB));
    chk(win_valid, winv);
    chk(bank_valid, bankv);
  endtask : op

  // a reset clears only the written flags, never the register contents
  task automatic rst();
    rstn = 1'b0;
    winv = 1'b0;
    bankv = 1'b0;
    u_core.drive(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge clk);
    chk({pm_rd, bank_rd, bank_wr, base_ram, watchdog, wo_read, bank_multi, win_valid, bank_valid}, 0);
    rstn = 1'b1;
  endtask : rst

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hAC22552E));
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    // the position is undefined after power-up, so it is written before any window read
    op(1'b0, 1'b1, 8'hC9, 8'h00);
    op(1'b1, 1'b0, 8'h40, 8'h00);
    // positions at both field ends and with unused bits set, both window edges back to back
    foreach (wp[i]) begin
      op(1'b0, 1'b1, 8'hC9, wp[i]);
      op(1'b1, 1'b0, 8'h40, 8'h00);
      op(1'b1, 1'b0, 8'h7F, 8'h00);
      op(1'b0, 1'b1, 8'h55, 8'hA5);
    end
    // every bank code, including unavailable and several-bit values
    foreach (bc[i]) begin
      op(1'b0, 1'b1, 8'hCB, bc[i]);
      op(1'b1, 1'b0, 8'h00, 8'h00);
      op(1'b0, 1'b1, 8'h3F, 8'($urandom));
      op(1'b1, 1'b1, 8'($urandom) & 8'h3F, 8'($urandom));
    end
    // full address sweep, reads then writes
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 256; a++) op(p == 0, p == 1, 8'(a), 8'($urandom));
    end
    // mid-run reset: the position and bank contents must survive
    op(1'b0, 1'b1, 8'hC9, 8'h2A);
    op(1'b0, 1'b1, 8'hCB, 8'h02);
    rst();
    op(1'b1, 1'b0, 8'h41, 8'h00);
    op(1'b1, 1'b0, 8'h05, 8'h00);
    for (int i = 0; i < 400; i++) op(1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
    op(1'b0, 1'b0, 8'($urandom), 8'($urandom));
    results();
  end

  // watchdog: the whole run is about 970 cycles
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule : data_space_window_bank_decode_bench
`default_nettype wire
